// file: rtl/pec_pkg.sv
/*
 * Shared constants and types of the branch-retirement event selection
 * front end: register offsets, field positions, codes and reset values.
 * Assumes a 32-bit APB master with byte strobes and a 12-bit address.
 */
package pec_pkg;

  // ---------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------
  localparam int          PEC_NUM_CNT   = 6;    // counters 12 .. 17
  localparam int          PEC_FIRST_CNT = 12;   // number of the first one
  localparam int          PEC_CNT_W     = 40;
  localparam int          PEC_EV_W      = 4;

  // ---------------------------------------------------------------------
  // event selection register fields
  // ---------------------------------------------------------------------
  localparam int          PEC_CLASS_MSB = 31;
  localparam int          PEC_CLASS_LSB = 25;
  localparam int          PEC_MASK_MSB  = 24;
  localparam int          PEC_MASK_LSB  = 9;
  localparam int          PEC_SUP_BIT   = 3;    // supervisor qualifier
  localparam int          PEC_USR_BIT   = 2;    // user qualifier
  localparam logic [31:0] PEC_SEL_WMASK = 32'hFFFF_FE0C;
  localparam logic [31:0] PEC_SEL_RST   = 32'h0000_0000;
  localparam logic [6:0]  PEC_CLASS_BR_RETIRED = 7'h06;

  // sub-event mask bits of the branch retirement class
  localparam int          PEC_NOT_TAKEN_PREDICTED_BIT    = 0;
  localparam int          PEC_NOT_TAKEN_MISPREDICTED_BIT = 1;
  localparam int          PEC_TAKEN_PREDICTED_BIT        = 2;
  localparam int          PEC_TAKEN_MISPREDICTED_BIT     = 3;

  // ---------------------------------------------------------------------
  // counter configuration register fields
  // ---------------------------------------------------------------------
  localparam int          PEC_SELR_MSB  = 15;
  localparam int          PEC_SELR_LSB  = 13;
  localparam int          PEC_EN_BIT    = 12;
  localparam logic [31:0] PEC_CFG_WMASK = 32'h0000_F000;
  localparam logic [31:0] PEC_CFG_RST   = 32'h0000_0000;
  localparam logic [2:0]  PEC_SELR_RETIRE = 3'h5;
  // bit k set: counter k is fed by selector three, else by selector two
  localparam logic [5:0]  PEC_SEL3_MAP  = 6'h2C;

  // ---------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [11:0] PEC_OFS_SEL_TWO   = 12'h000;
  localparam logic [11:0] PEC_OFS_SEL_THREE = 12'h004;
  localparam logic [11:0] PEC_OFS_CFG_BASE  = 12'h010;
  localparam logic [11:0] PEC_CFG_SPAN      = 12'h018;
  localparam logic [11:0] PEC_OFS_CNT_BASE  = 12'h040;
  localparam logic [11:0] PEC_CNT_SPAN      = 12'h030;

  // ---------------------------------------------------------------------
  // register state of the top module
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [1:0][31:0]             sel;    // selectors two and three
    logic [PEC_NUM_CNT-1:0][31:0] cfg;    // counter configuration
    logic [PEC_NUM_CNT-1:0][7:0]  stage;  // staged counter high bytes
    logic [31:0]                  rdata;
    logic                         ready;
    logic                         err;
  } pec_top_s;

endpackage : pec_pkg

// file: rtl/pec_counter_slice.sv
/*
 * One performance counter with its event qualification: class decode,
 * sub-event mask, privilege gate, routing check and a wrapping count.
 * Assumes event lines and the privilege level come from logic on pclk.
 */
module pec_counter_slice #(
  parameter int CNT_W = pec_pkg::PEC_CNT_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [31:0]      sel_word,
  input  wire logic [31:0]      cfg_word,
  input  wire logic [3:0]       retire_ev,
  input  wire logic             user_mode,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic      [CNT_W-1:0] count
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
  } pec_slice_s;

  pec_slice_s st_r;
  pec_slice_s st_nxt;
  logic [6:0] ev_class;
  logic [3:0] matched;
  logic [2:0] inc;
  logic       priv_ok;
  logic       routed;

  // ---------------------------------------------------------------------
  // qualification and next count
  // ---------------------------------------------------------------------
  always_comb begin
    ev_class = sel_word[pec_pkg::PEC_CLASS_MSB:pec_pkg::PEC_CLASS_LSB];
    // privilege gate follows the class decode in the qualification chain
    priv_ok  = user_mode ? sel_word[pec_pkg::PEC_USR_BIT]
                         : sel_word[pec_pkg::PEC_SUP_BIT];   // [R11]
    routed   = cfg_word[pec_pkg::PEC_EN_BIT] &&
               (cfg_word[pec_pkg::PEC_SELR_MSB:pec_pkg::PEC_SELR_LSB] ==
                pec_pkg::PEC_SELR_RETIRE);                   // [R5]
    // only the branch class is wired here; other codes count nothing
    matched  = (ev_class == pec_pkg::PEC_CLASS_BR_RETIRED && priv_ok &&
                routed) ? (retire_ev &
                sel_word[pec_pkg::PEC_MASK_LSB +: 4]) : 4'h0; // [R1] [R14]
    inc      = 3'h0;
    for (int i = 0; i < 4; i++) begin
      inc = inc + {2'b00, matched[i]};                       // [R3]
    end
    st_nxt       = st_r;
    // a software load beats the increment of the same cycle
    st_nxt.count = load ? load_val                           // [R13]
                        : st_r.count + CNT_W'(inc);          // [R7]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.count;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_class_decode: assert property (inc != 3'h0 |->   // [R1]
    ev_class == pec_pkg::PEC_CLASS_BR_RETIRED)
    else $error("count with wrong event class");
  a_empty_mask: assert property (                    // [R14]
    sel_word[pec_pkg::PEC_MASK_LSB +: 4] == 4'h0 |-> inc == 3'h0)
    else $error("count with empty sub-event mask");
  a_priv_gate: assert property (!priv_ok |-> inc == 3'h0) // [R11]
    else $error("count at disabled privilege level");
  a_route_gate: assert property (inc != 3'h0 |->     // [R5]
    cfg_word[pec_pkg::PEC_SELR_MSB:pec_pkg::PEC_SELR_LSB] ==
    pec_pkg::PEC_SELR_RETIRE)
    else $error("count without retirement selector");
  a_count_step: assert property (!load |=>           // [R7]
    st_r.count == $past(st_r.count) + CNT_W'($past(inc)))
    else $error("counter did not add its increment");
  a_load_all: assert property (load |=>              // [R13]
    st_r.count == $past(load_val))
    else $error("counter load lost bits");
  a_tally_full: assert property (                    // [R3]
    routed && priv_ok && retire_ev == 4'hF &&
    sel_word[pec_pkg::PEC_MASK_LSB +: 4] == 4'hF &&
    ev_class == pec_pkg::PEC_CLASS_BR_RETIRED |-> inc == 3'h4)
    else $error("not every matching branch counted");

  c_wrap: cover property (!load && st_r.count == '1 && inc != 3'h0);
  c_multi: cover property (inc > 3'h1);
  c_load: cover property (load);

endmodule : pec_counter_slice

// file: rtl/pec_event_select.sv
/*
 * Top of the branch-retirement event selection front end: APB slave with
 * two event selection registers, six counter configuration registers and
 * six 40-bit counters (documented numbers 12 to 17).
 * Assumes an APB master on pclk and event lines synchronous to pclk.
 */
// Our own choices: register access over APB and the register offsets.
// Functional notes
// R1: event class in bits 31:25; code 06 counts retired branches
// R2: sub-event mask sits in bits 24:9, relative bit 0 at bit 9
// R3: mask bits NT-pred, NT-mispred, T-pred, T-mispred; any set bit counts
// R4: software writes zero to undefined mask bits
// R5: config bits 15:13 are a selector index; 5 picks retirement selectors
// R6: selector two feeds counters 12,13,16; selector three 14,15,17
// R7: enabled counter counts forever and wraps at its maximum
// R8: software writes both privilege flags with class and mask
// R9: software programs selection register before the config selector
// R10: one write or several partial writes give the same config
// R11: count only at privilege levels enabled by the qualifier flags
// R12: every counter config register resets to zero
// R13: counters are 40 bits; a software write replaces every bit
// R14: unsupported class or empty mask passes no event
// R15: selection register class, mask and flags reset to zero
module pec_event_select (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  br_retire_ev,
  input  wire logic        user_mode
);

  localparam int N = pec_pkg::PEC_NUM_CNT;
  localparam int W = pec_pkg::PEC_CNT_W;

  pec_pkg::pec_top_s    st_r;
  pec_pkg::pec_top_s    st_nxt;
  logic [N-1:0][W-1:0]  cnt_val;
  logic [N-1:0]         cnt_load;
  logic [W-1:0]         cnt_load_val;
  logic [11:0]          cfg_off;
  logic [11:0]          cnt_off;
  logic [2:0]           cfg_k;
  logic [2:0]           cnt_k;
  logic                 cfg_hit;
  logic                 cnt_hit;
  logic                 hit;
  logic [31:0]          rd;
  logic                 wr_fire;

  // ---------------------------------------------------------------------
  // byte-lane merge of a write into a register
  // ---------------------------------------------------------------------
  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old_v,
    input logic [31:0] wdata,
    input logic [3:0]  strb,
    input logic [31:0] wmask
  );
    logic [31:0] v;
    v = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        v[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    // reserved bits never store, so they read back as zero
    merge_lanes = v & wmask;
  endfunction : merge_lanes

  // ---------------------------------------------------------------------
  // address decode and read mux
  // ---------------------------------------------------------------------
  always_comb begin
    cfg_off = paddr - pec_pkg::PEC_OFS_CFG_BASE;
    cnt_off = paddr - pec_pkg::PEC_OFS_CNT_BASE;
    cfg_k   = cfg_off[4:2];
    cnt_k   = cnt_off[5:3];
    cfg_hit = paddr >= pec_pkg::PEC_OFS_CFG_BASE &&
              cfg_off < pec_pkg::PEC_CFG_SPAN && paddr[1:0] == 2'b00;
    cnt_hit = paddr >= pec_pkg::PEC_OFS_CNT_BASE &&
              cnt_off < pec_pkg::PEC_CNT_SPAN && paddr[1:0] == 2'b00;
    hit     = 1'b1;
    rd      = 32'h0000_0000;
    if (paddr == pec_pkg::PEC_OFS_SEL_TWO) begin
      rd = st_r.sel[0];
    end else if (paddr == pec_pkg::PEC_OFS_SEL_THREE) begin
      rd = st_r.sel[1];
    end else if (cfg_hit) begin
      rd = st_r.cfg[cfg_k];
    end else if (cnt_hit) begin
      rd = cnt_off[2] ? {24'h00_0000, cnt_val[cnt_k][W-1:32]}
                      : cnt_val[cnt_k][31:0];
    end else begin
      hit = 1'b0;
    end
  end

  assign wr_fire = psel && penable && st_r.ready && pwrite;

  // ---------------------------------------------------------------------
  // register updates and apb answer, one wait state per access
  // ---------------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.ready = 1'b0;
    st_nxt.err   = 1'b0;
    st_nxt.rdata = 32'h0000_0000;
    cnt_load     = '0;
    cnt_load_val = {st_r.stage[cnt_k], pwdata};
    // answer is prepared in the first access cycle so outputs are flops
    if (psel && penable && !st_r.ready) begin
      st_nxt.ready = 1'b1;
      st_nxt.err   = !hit;
      st_nxt.rdata = pwrite ? 32'h0000_0000 : rd;
    end
    // writes take effect only on the completing edge
    if (wr_fire && hit) begin
      if (paddr == pec_pkg::PEC_OFS_SEL_TWO) begin
        st_nxt.sel[0] = merge_lanes(st_r.sel[0], pwdata, pstrb,
                                    pec_pkg::PEC_SEL_WMASK);    // [R2]
      end else if (paddr == pec_pkg::PEC_OFS_SEL_THREE) begin
        st_nxt.sel[1] = merge_lanes(st_r.sel[1], pwdata, pstrb,
                                    pec_pkg::PEC_SEL_WMASK);    // [R2]
      end else if (cfg_hit) begin
        // untouched lanes keep their bits, so split writes compose
        st_nxt.cfg[cfg_k] = merge_lanes(st_r.cfg[cfg_k], pwdata, pstrb,
                                        pec_pkg::PEC_CFG_WMASK); // [R10]
      end else if (cnt_off[2]) begin
        st_nxt.stage[cnt_k] = pwdata[7:0];
      end else begin
        // low word commits staged high byte and all 32 low bits at once
        cnt_load[cnt_k] = 1'b1;                                 // [R13]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r       <= '0;                                   // [R12] [R15]
      st_r.sel   <= {2{pec_pkg::PEC_SEL_RST}};            // [R15]
      st_r.cfg   <= {N{pec_pkg::PEC_CFG_RST}};            // [R12]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata  = st_r.rdata;
  assign pready  = st_r.ready;
  assign pslverr = st_r.err;

  // ---------------------------------------------------------------------
  // counters, each tied to its fixed retirement selector
  // ---------------------------------------------------------------------
  for (genvar k = 0; k < N; k++) begin : g_cnt
    pec_counter_slice #(
      .CNT_W (W)
    ) u_slice (
      .pclk      (pclk),
      .presetn   (presetn),
      .sel_word  (st_r.sel[pec_pkg::PEC_SEL3_MAP[k]]),    // [R6]
      .cfg_word  (st_r.cfg[k]),
      .retire_ev (br_retire_ev),
      .user_mode (user_mode),
      .load      (cnt_load[k]),
      .load_val  (cnt_load_val),
      .count     (cnt_val[k])
    );
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cfg_reset: assert property ($rose(presetn) |->        // [R12]
    st_r.cfg == '0)
    else $error("config not zero after reset");
  a_sel_reset: assert property ($rose(presetn) |->        // [R15]
    st_r.sel == '0)
    else $error("selection register not zero after reset");
  a_mask_field: assert property (                         // [R2]
    wr_fire && paddr == pec_pkg::PEC_OFS_SEL_TWO && pstrb == 4'hF |=>
    st_r.sel[0][24:9] == $past(pwdata[24:9]))
    else $error("sub-event mask not stored at bits 24:9");
  a_cfg_split: assert property (                          // [R10]
    wr_fire && cfg_hit && !pstrb[1] |=>
    st_r.cfg[$past(cfg_k)] == $past(st_r.cfg[cfg_k]))
    else $error("config changed by unstrobed lane");
  a_route_map: assert property (                          // [R6]
    st_r.sel[1] == '0 |-> ##1 (cnt_val[2] == $past(cnt_val[2]) ||
    $past(cnt_load[2])))
    else $error("counter 14 fed by selector two");
  a_one_wait: assert property (psel && penable && !st_r.ready |=>
    st_r.ready ##1 !st_r.ready)
    else $error("apb answer not after one wait state");

  c_rd_cnt: cover property (psel && penable && st_r.ready && cnt_hit);
  c_err: cover property (st_r.err);
  c_split_wr: cover property (wr_fire && cfg_hit && pstrb != 4'hF);

endmodule : pec_event_select

// file: bench/pec_ev_src.sv
/*
 * Model of the retirement hardware that feeds the event lines: plays a
 * burst of one retirement pattern for a given number of cycles.
 * Assumes the bench pulses go for one cycle with the pattern set up.
 */
module pec_ev_src (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic [3:0] pat,
  input  wire logic       user_level_qualifier,
  input  wire logic [7:0] len,
  output logic      [3:0] ev,
  output logic            user_mode
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] left_r;

  // ---------------------------------------------------------------------
  // burst player
  // ---------------------------------------------------------------------
  // lines return to zero between bursts: no retirement is a real value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r    <= 8'h00;
      ev        <= 4'h0;
      user_mode <= 1'b0;
    end else if (go) begin
      left_r    <= len - 8'h01;
      ev        <= pat;
      user_mode <= user_level_qualifier;
    end else if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
    end else begin
      ev <= 4'h0;
    end
  end
endmodule : pec_ev_src

// file: bench/tb.sv
/*
 * Self-checking bench of the event selection front end: APB tasks,
 * register and counting scenarios against the retirement line model.
 * Assumes the slave answers with pready; the master waits for it.
 */
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk    = 1'b0;
  logic        presetn;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [3:0]  pstrb   = 4'h0;
  logic        go      = 1'b0;
  logic [3:0]  pat     = 4'h0;
  logic        user_level_qualifier     = 1'b0;
  logic [7:0]  len     = 8'h01;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  ev;
  logic        user_mode;
  logic [31:0] rdv;
  logic        errv;
  int          failures  = 0;
  int          tests_run = 0;

  // 50 MHz
  always #10 pclk = ~pclk;

  pec_event_select uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .br_retire_ev(ev), .user_mode(user_mode)
  );

  pec_ev_src src (
    .pclk(pclk), .presetn(presetn), .go(go), .pat(pat), .user_level_qualifier(user_level_qualifier),
    .len(len), .ev(ev), .user_mode(user_mode)
  );

  // ---------------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------------
  // request held until the rising edge with pready high; pready and data
  // are looked at on the falling edge before it, where they have settled
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(negedge pclk);
      n++;
    end
    if (n == 16) failures++;
    rdv = prdata;
    errv = pslverr;
    // completing edge: the write lands here, only then is all released
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk({8'h00, rdv}, {8'h00, e});
  endtask : rd

  // refused access: error flag with zero data
  task automatic rde(input logic [11:0] a);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk({8'h00, rdv}, 40'h0);
    chk({39'h0, errv}, 40'h1);
  endtask : rde

  function automatic logic [11:0] cfga(int k);
    return pec_pkg::PEC_OFS_CFG_BASE + 12'(4 * k);
  endfunction : cfga

  function automatic logic [11:0] cnta(int k);
    return pec_pkg::PEC_OFS_CNT_BASE + 12'(8 * k);
  endfunction : cnta

  function automatic logic [31:0] sw(logic [6:0] c, logic [15:0] m,
                                     logic [1:0] f);
    return {c, m, 5'h00, f, 2'h0};
  endfunction : sw

  // high byte staged first, low word then loads all 40 bits
  task automatic ld(input int k, input logic [39:0] v);
    wr(cnta(k) + 12'h004, {24'h0, v[39:32]});
    wr(cnta(k), v[31:0]);
  endtask : ld

  task automatic cchk(input int k, input logic [39:0] e);
    logic [7:0] hi;
    xfer(1'b0, cnta(k) + 12'h004, 32'h0, 4'hF);
    hi = rdv[7:0];
    xfer(1'b0, cnta(k), 32'h0, 4'hF);
    chk({hi, rdv}, e);
  endtask : cchk

  task automatic burst(input logic [3:0] p, input logic u, input int n);
    @(posedge pclk);
    go <= 1'b1;
    pat <= p;
    user_level_qualifier <= u;
    len <= 8'(n);
    @(posedge pclk);
    go <= 1'b0;
    repeat (n + 3) @(posedge pclk);
  endtask : burst

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  initial begin
    // x to 0 gives the asynchronous reset its falling edge
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    for (int k = 0; k < 6; k++) begin
      rd(cfga(k), 32'h0);
      cchk(k, 40'h0);
    end
    $display("test reset done");
    // reserved bits read zero, strobes gate lanes
    wr(12'h000, 32'hFFFF_FFFF);
    rd(12'h000, pec_pkg::PEC_SEL_WMASK);
    wr(cfga(0), 32'hFFFF_FFFF);
    rd(cfga(0), pec_pkg::PEC_CFG_WMASK);
    xfer(1'b1, cfga(0), 32'h0, 4'h1);
    rd(cfga(0), pec_pkg::PEC_CFG_WMASK);
    rde(12'h008);
    rde(12'h002);
    $display("test access done");
    // selectors first, then routing; counter 13 set in two writes
    wr(12'h000, sw(7'h06, 16'h000F, 2'h3));
    wr(12'h004, sw(7'h06, 16'h0000, 2'h3));
    for (int k = 0; k < 6; k++) begin
      if (k == 1) wr(cfga(1), 32'h0000_A000);
      wr(cfga(k), 32'h0000_B000);
    end
    burst(4'h5, 1'b1, 10);
    for (int k = 0; k < 6; k++) begin
      cchk(k, (k == 0 || k == 1 || k == 4) ? 40'd20 : 40'd0);
    end
    $display("test routing done");
    // each mask bit alone, the other bits fired against it
    for (int i = 0; i < 4; i++) begin
      wr(12'h000, sw(7'h06, 16'h0001 << i, 2'h3));
      ld(0, 40'h0);
      burst(4'hF ^ (4'h1 << i), 1'b1, 4);
      burst(4'h1 << i, 1'b1, 5);
      cchk(0, 40'd5);
    end
    $display("test mask done");
    // user only, then supervisor only
    wr(12'h000, sw(7'h06, 16'h000F, 2'h1));
    ld(0, 40'h0);
    burst(4'h1, 1'b0, 6);
    burst(4'h1, 1'b1, 6);
    cchk(0, 40'd6);
    wr(12'h000, sw(7'h06, 16'h000F, 2'h2));
    burst(4'h1, 1'b0, 3);
    burst(4'h1, 1'b1, 3);
    cchk(0, 40'd9);
    $display("test privilege done");
    // wrong class code, then wrong selector index
    wr(12'h000, sw(7'h07, 16'h000F, 2'h3));
    ld(0, 40'h0);
    burst(4'hF, 1'b1, 4);
    cchk(0, 40'h0);
    wr(12'h000, sw(7'h06, 16'h000F, 2'h3));
    wr(cfga(0), 32'h0000_9000);
    burst(4'hF, 1'b1, 4);
    cchk(0, 40'h0);
    $display("test decode done");
    // full-width load while disabled, then wrap at the top
    wr(cfga(0), 32'h0000_A000);
    ld(0, 40'hAB_1234_5678);
    burst(4'hF, 1'b1, 4);
    cchk(0, 40'hAB_1234_5678);
    wr(cfga(0), 32'h0000_B000);
    ld(0, 40'hFF_FFFF_FFFE);
    burst(4'h1, 1'b1, 3);
    cchk(0, 40'h1);
    $display("test wrap done");
    // reset in mid-run clears everything that was programmed
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    rd(cfga(0), 32'h0);
    cchk(0, 40'h0);
    $display("test second reset done");
    test_done();
  end

  // a hang ends the run as a failure
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    test_done();
  end
endmodule : tb
